//--- tpir_pkg.sv
`default_nettype none
package tpir_pkg;
    // Register word offsets (byte addresses, aligned words)
    localparam logic [11:0] ADDR_RDY_CTRL    = 12'hEF0;
    localparam logic [11:0] ADDR_DATA_SRC2   = 12'hEEC;
    localparam logic [11:0] ADDR_DATA_SRC1   = 12'hEFC;
    localparam logic [11:0] ADDR_VALID_RB    = 12'hEF8;
    localparam logic [11:0] ADDR_MODE_CTRL   = 12'hF00;
    localparam logic [11:0] ADDR_CAP_ID      = 12'hFC8;
    localparam logic [11:0] ADDR_TYPE_ID     = 12'hFCC;

    // Mode field codes
    localparam logic [1:0]  MODE_NORMAL      = 2'h0;
    localparam logic [1:0]  MODE_ITEST       = 2'h1;
    localparam logic [1:0]  MODE_IDATA       = 2'h2;
    localparam logic [1:0]  MODE_RESET       = 2'h0;

    // Capability field positions and values
    localparam int          CAP_NRZ_BIT      = 11;
    localparam int          CAP_MAN_BIT      = 10;
    localparam int          CAP_PAR_BIT      = 9;
    localparam int          CAP_BUF_LSB      = 6;
    localparam logic [2:0]  CAP_BUF_4B       = 3'h2;
    localparam int          CAP_ASYNC_BIT    = 5;
    localparam logic [4:0]  CAP_IN_ONE       = 5'h00;
    localparam logic [4:0]  CAP_IN_TWO       = 5'h01;

    // Data register field positions
    localparam int          DR_V2_BIT        = 29;
    localparam int          DR_C2_LSB        = 27;
    localparam int          DR_V1_BIT        = 26;
    localparam int          DR_C1_LSB        = 24;

    // Device type code, value is arbitrary
    localparam logic [7:0]  TYPE_CODE_DFLT   = 8'h5A;
endpackage
`default_nettype wire

//--- tpir_capture.sv
`timescale 1ns/100ps
`default_nettype none
module tpir_capture (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_enable,
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_consume,
    output logic             o_ready,
    output logic [1:0]       o_count,
    output logic [23:0]      o_bytes
);
    logic [1:0]  cnt_ff;
    logic [23:0] buf_ff;

    // Accept while enabled and room left
    assign o_ready = i_enable && (cnt_ff != 2'h3);
    assign o_count = cnt_ff;
    assign o_bytes = buf_ff;

    // Byte store; consume empties it, a new byte in that cycle survives
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_ff <= 2'h0;
            buf_ff <= 24'h000000;
        end else if (i_consume) begin
            cnt_ff <= (i_valid && o_ready) ? 2'h1 : 2'h0;
            buf_ff <= {16'h0000, (i_valid && o_ready) ? i_data : 8'h00};
        end else if (i_valid && o_ready) begin
            cnt_ff <= cnt_ff + 2'h1;
            buf_ff <= {buf_ff[15:0], i_data};
        end
    end
endmodule
`default_nettype wire

//--- tpir_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tpir_regs #(
    parameter bit         HAS_SRC1  = 1'b1,
    parameter logic [7:0] TYPE_CODE = tpir_pkg::TYPE_CODE_DFLT
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_trace_src1_valid,
    input  wire logic [7:0]  i_trace_src1_data,
    input  wire logic        i_trace_src2_valid,
    input  wire logic [7:0]  i_trace_src2_data,
    input  wire logic        i_func_ready1,
    input  wire logic        i_func_ready2,
    output logic             o_trace_src1_ready,
    output logic             o_trace_src2_ready,
    output logic             o_trace_out_en,
    output logic      [1:0]  o_mode
);
    import tpir_pkg::*;

    typedef enum logic [1:0] {TPIR_NORMAL, TPIR_ITEST, TPIR_IDATA} tpir_mode_t;

    ////////////////////////////////////////////////////////////////////
    logic [1:0]  mode_ff;
    logic        rdy_bit_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    tpir_mode_t  mode_sel;
    logic        cons1;
    logic        cons2;
    logic        cap_rdy1;
    logic        cap_rdy2;
    logic [1:0]  cnt1;
    logic [1:0]  cnt2;
    logic [23:0] byt1;
    logic [23:0] byt2;

    // Builds the shared data register word for either source
    function automatic logic [31:0] data_word(input logic [1:0] c,
                                              input logic [23:0] b);
        logic [31:0] w;
        w = 32'h00000000;
        w[DR_V2_BIT]            = i_trace_src2_valid;
        w[DR_C2_LSB +: 2]       = cnt2;
        w[DR_V1_BIT]            = i_trace_src1_valid;
        w[DR_C1_LSB +: 2]       = cnt1;
        w[23:0]                 = b;
        data_word = (c == 2'h0) ? {w[31:24], 24'h000000} : w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Mode decode; reserved code falls back to normal
    // mode field decode
    always_comb begin
        case (mode_ff)
            MODE_ITEST: mode_sel = TPIR_ITEST;
            MODE_IDATA: mode_sel = TPIR_IDATA;
            MODE_NORMAL: mode_sel = TPIR_NORMAL;
            default:    mode_sel = TPIR_NORMAL;
        endcase
    end

    // Mode register
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            mode_ff <= MODE_RESET;
        end else if (i_wr && i_addr == ADDR_MODE_CTRL) begin
            mode_ff <= i_wdata[1:0];
        end
    end

    // Ready control bit, writable in any mode, steers readies only in MODE_ITEST
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rdy_bit_ff <= 1'b0;
        end else if (i_wr && i_addr == ADDR_RDY_CTRL) begin
            rdy_bit_ff <= i_wdata[0];
        end
    end

    assign o_mode = mode_ff;

    assign o_trace_out_en = (mode_sel != TPIR_IDATA);

    ////////////////////////////////////////////////////////////////////
    // Ready steering per mode
    // forced ready drive
    always_comb begin
        case (mode_sel)
            TPIR_ITEST: begin
                o_trace_src1_ready = rdy_bit_ff;
                o_trace_src2_ready = rdy_bit_ff;
            end
            TPIR_IDATA: begin
                o_trace_src1_ready = cap_rdy1;
                o_trace_src2_ready = cap_rdy2;
            end
            default: begin
                o_trace_src1_ready = i_func_ready1;
                o_trace_src2_ready = i_func_ready2;
            end
        endcase
    end

    assign cons1 = i_rd && (i_addr == ADDR_DATA_SRC1);
    assign cons2 = i_rd && (i_addr == ADDR_DATA_SRC2);

    // Capture stages only run in data test mode, so bytes never leak in
    // Limitation: bytes held when the mode changes stay until read out
    tpir_capture u_cap1 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (mode_sel == TPIR_IDATA),
        .i_valid    (i_trace_src1_valid),
        .i_data     (i_trace_src1_data),
        .i_consume  (cons1),
        .o_ready    (cap_rdy1),
        .o_count    (cnt1),
        .o_bytes    (byt1)
    );

    tpir_capture u_cap2 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (mode_sel == TPIR_IDATA),
        .i_valid    (i_trace_src2_valid),
        .i_data     (i_trace_src2_data),
        .i_consume  (cons2),
        .o_ready    (cap_rdy2),
        .o_count    (cnt2),
        .o_bytes    (byt2)
    );

    ////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses return zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (i_addr)
            ADDR_VALID_RB:  nxt_rdata[0] = i_trace_src1_valid | i_trace_src2_valid;
            ADDR_MODE_CTRL: nxt_rdata[1:0] = mode_ff;
            ADDR_RDY_CTRL:  nxt_rdata[0] = rdy_bit_ff;
            ADDR_DATA_SRC1: nxt_rdata = data_word(cnt1, byt1);
            ADDR_DATA_SRC2: nxt_rdata = data_word(cnt2, byt2);
            ADDR_CAP_ID: begin
                nxt_rdata[CAP_NRZ_BIT] = 1'b1;
                nxt_rdata[CAP_MAN_BIT] = 1'b1;
                nxt_rdata[CAP_PAR_BIT] = 1'b0;
                nxt_rdata[CAP_BUF_LSB +: 3] = CAP_BUF_4B;
                nxt_rdata[CAP_ASYNC_BIT] = 1'b1;
                nxt_rdata[4:0] = HAS_SRC1 ? CAP_IN_TWO : CAP_IN_ONE;
            end
            ADDR_TYPE_ID:   nxt_rdata[7:0] = TYPE_CODE;
            default:        nxt_rdata = 32'h00000000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    // Zero between reads so a stale word is never taken for fresh data
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rdata_ff <= 32'h00000000;
        end else if (i_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign o_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // Register side checks; read results are judged one cycle on
    // readback matches inputs
    a_valid_or: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_VALID_RB) |=>
        o_rdata[0] == ($past(i_trace_src1_valid) | $past(i_trace_src2_valid)))
        else $error("valid readback wrong");

    a_mode_write: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_wr && i_addr == ADDR_MODE_CTRL) |=> o_mode == $past(i_wdata[1:0]))
        else $error("mode write lost");

    a_mode_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !(i_wr && i_addr == ADDR_MODE_CTRL) |=> $stable(o_mode))
        else $error("mode changed without a write");

    a_ready_normal: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == MODE_NORMAL) |->
        (o_trace_src1_ready == i_func_ready1 && o_trace_src2_ready == i_func_ready2))
        else $error("normal mode readies wrong");

    a_out_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_trace_out_en == (o_mode != MODE_IDATA))
        else $error("trace output gate wrong");

    a_full_refuse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == MODE_IDATA) |->
        (o_trace_src1_ready == (cnt1 != 2'h3) && o_trace_src2_ready == (cnt2 != 2'h3)))
        else $error("capture ready wrong");

    // accepted first source byte is counted
    a_src1_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == MODE_IDATA && i_trace_src1_valid && o_trace_src1_ready && !cons1) |=>
        cnt1 == $past(cnt1) + 2'h1)
        else $error("accepted byte not counted");

    // accepted second source byte is counted
    a_src2_count: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == MODE_IDATA && i_trace_src2_valid && o_trace_src2_ready && !cons2) |=>
        cnt2 == $past(cnt2) + 2'h1)
        else $error("second source byte not counted");

    a_data_valids: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_DATA_SRC1) |=>
        (o_rdata[DR_V1_BIT] == $past(i_trace_src1_valid) &&
         o_rdata[DR_V2_BIT] == $past(i_trace_src2_valid)))
        else $error("data register valids wrong");

    a_cap_word: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_CAP_ID) |=>
        o_rdata == {20'h00000, 7'b1100101, 5'(HAS_SRC1)})
        else $error("capability word wrong");

    sequence s_type_write;
        i_wr && i_addr == ADDR_TYPE_ID;
    endsequence
    sequence s_type_read;
        i_rd && i_addr == ADDR_TYPE_ID;
    endsequence
    a_type_fixed: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_type_write ##[1:2] s_type_read |=> o_rdata == {24'h000000, TYPE_CODE})
        else $error("type register changed");

    a_ready_force: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == MODE_ITEST) |->
        (o_trace_src1_ready == rdy_bit_ff && o_trace_src2_ready == rdy_bit_ff))
        else $error("forced ready wrong");

    a_rdy_readback: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == ADDR_RDY_CTRL) |=> o_rdata == {31'h0, $past(rdy_bit_ff)})
        else $error("ready bit readback wrong");

    sequence s_data_read;
        i_rd && i_addr == ADDR_DATA_SRC1 && !i_trace_src1_valid;
    endsequence
    a_read_consume: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_data_read |=> cnt1 == 2'h0)
        else $error("read did not consume");

    sequence s_src2_read;
        i_rd && i_addr == ADDR_DATA_SRC2 && !i_trace_src2_valid;
    endsequence
    a_src2_consume: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_src2_read |=> cnt2 == 2'h0)
        else $error("second read did not consume");

    a_rsvd_norm: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode == 2'h3) |-> (o_trace_out_en && o_trace_src1_ready == i_func_ready1 &&
        o_trace_src2_ready == i_func_ready2))
        else $error("reserved mode not normal");
endmodule
`default_nettype wire

//--- tpir_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// Trace source stand-in: offers one byte and holds it until accepted
module tpir_src_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_send,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_ready,
    output logic            o_valid,
    output logic [7:0]      o_data
);
    // Data flips once taken, so a stale byte never reads as fresh
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_valid <= 1'b0;
            o_data  <= 8'h00;
        end else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_data  <= ~o_data;
        end else if (!o_valid && i_send) begin
            o_valid <= 1'b1;
            o_data  <= i_byte;
        end
    end
endmodule
`default_nettype wire

//--- trace_port_integration_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module trace_port_integration_regs_tb;
    import tpir_pkg::*;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [11:0] addr  = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        fr1   = 1'b1;
    logic        fr2   = 1'b0;
    logic [1:0]  snd   = 2'h0;
    logic [7:0]  byt   = 8'h00;
    logic [31:0] rdata;
    logic [7:0]  d1, d2;
    logic [1:0]  mode;
    logic        v1, v2, r1, r2, out_en;
    int          errors    = 0;
    int          tests_run = 0;

    // 20 MHz core clock
    always #25 clk = ~clk;

    tpir_regs dut (.i_core_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_trace_src1_valid(v1),
        .i_trace_src1_data(d1), .i_trace_src2_valid(v2), .i_trace_src2_data(d2),
        .i_func_ready1(fr1), .i_func_ready2(fr2), .o_trace_src1_ready(r1),
        .o_trace_src2_ready(r2), .o_trace_out_en(out_en), .o_mode(mode));
    tpir_src_model u_src1 (.i_core_clk(clk), .i_sys_rst(rst), .i_send(snd[0]),
        .i_byte(byt), .i_ready(r1), .o_valid(v1), .o_data(d1));
    tpir_src_model u_src2 (.i_core_clk(clk), .i_sys_rst(rst), .i_send(snd[1]),
        .i_byte(byt), .i_ready(r2), .o_valid(v2), .o_data(d2));

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask

    // Offer a byte; optionally wait, bounded, until it is taken
    task automatic send(input int s, input logic [7:0] b, input bit wt);
        int n;
        @(posedge clk);
        snd[s] <= 1'b1;
        byt <= b;
        @(posedge clk);
        snd[s] <= 1'b0;
        #1;
        n = 0;
        while (wt && (s == 1 ? v2 : v1) && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 8) begin
            errors++;
            $display("FAIL %0t byte never accepted", $time);
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        chk({30'h0, mode}, {30'h0, MODE_RESET}, "reset mode");
        chk({31'h0, out_en}, 32'h1, "reset out_en");
        chk({30'h0, r2, r1}, {30'h0, fr2, fr1}, "reset readies");
        rd_reg(ADDR_DATA_SRC1, 32'h0, "reset capture");
        $display("test reset done");
    endtask

    task automatic t_ids();
        rd_reg(ADDR_CAP_ID, 32'h0000_0CA1, "capability");
        rd_reg(ADDR_TYPE_ID, {24'h0, TYPE_CODE_DFLT}, "type");
        wr_reg(ADDR_TYPE_ID, 32'hFFFF_FFFF);
        rd_reg(ADDR_TYPE_ID, {24'h0, TYPE_CODE_DFLT}, "type after write");
        wr_reg(ADDR_CAP_ID, 32'h0);
        rd_reg(ADDR_CAP_ID, 32'h0000_0CA1, "capability after write");
        rd_reg(12'h004, 32'h0, "unmapped");
        $display("test ids done");
    endtask

    // Stalled sources keep their valids up, giving all four combinations
    task automatic t_valid();
        @(posedge clk);
        fr1 <= 1'b0;
        fr2 <= 1'b0;
        send(0, 8'h11, 1'b0);
        rd_reg(ADDR_VALID_RB, 32'h1, "valid src1");
        send(1, 8'h22, 1'b0);
        rd_reg(ADDR_VALID_RB, 32'h1, "valid both");
        @(posedge clk);
        fr1 <= 1'b1;
        rd_reg(ADDR_VALID_RB, 32'h1, "valid src2");
        @(posedge clk);
        fr2 <= 1'b1;
        rd_reg(ADDR_VALID_RB, 32'h0, "valid none");
        $display("test valid done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            wr_reg(ADDR_MODE_CTRL, 32'(m));
            #1;
            chk({30'h0, mode}, 32'(m), "mode out");
            chk({31'h0, out_en}, (m == 2) ? 32'h0 : 32'h1, "out_en");
            rd_reg(ADDR_MODE_CTRL, 32'(m), "mode read");
        end
        wr_reg(ADDR_MODE_CTRL, 32'h3);
        fr1 <= 1'b0;
        #1;
        chk({31'h0, out_en}, 32'h1, "reserved out_en");
        chk({30'h0, r2, r1}, 32'h2, "reserved readies");
        $display("test modes done");
    endtask

    task automatic t_itest();
        wr_reg(ADDR_MODE_CTRL, {30'h0, MODE_ITEST});
        wr_reg(ADDR_RDY_CTRL, 32'h1);
        fr2 <= 1'b0;
        #1;
        chk({30'h0, r2, r1}, 32'h3, "itest ready high");
        rd_reg(ADDR_RDY_CTRL, 32'h1, "ready bit read");
        wr_reg(ADDR_RDY_CTRL, 32'h0);
        fr1 <= 1'b1;
        fr2 <= 1'b1;
        #1;
        chk({30'h0, r2, r1}, 32'h0, "itest ready low");
        wr_reg(ADDR_RDY_CTRL, 32'h1);
        wr_reg(ADDR_MODE_CTRL, {30'h0, MODE_NORMAL});
        fr1 <= 1'b0;
        fr2 <= 1'b0;
        #1;
        chk({30'h0, r2, r1}, 32'h0, "normal ignores bit");
        $display("test itest done");
    endtask

    // Fill src1 to three bytes, then drain both through reads
    task automatic t_data();
        wr_reg(ADDR_MODE_CTRL, {30'h0, MODE_IDATA});
        send(0, 8'hA1, 1'b1);
        send(0, 8'hA2, 1'b1);
        send(0, 8'hA3, 1'b1);
        chk({31'h0, r1}, 32'h0, "full ready");
        send(1, 8'hB7, 1'b1);
        rd_reg(ADDR_DATA_SRC1, 32'h0BA1_A2A3, "src1 data");
        rd_reg(ADDR_DATA_SRC1, 32'h0800_0000, "src1 drained");
        rd_reg(ADDR_DATA_SRC2, 32'h0800_00B7, "src2 data");
        rd_reg(ADDR_DATA_SRC2, 32'h0, "src2 drained");
        chk({31'h0, r1}, 32'h1, "ready again");
        $display("test data done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_ids();
        t_valid();
        t_modes();
        t_itest();
        t_data();
        tally_and_finish();
    end
endmodule
`default_nettype wire
